// File: rtl/frs_pkg.sv
// Constants and types shared by the flash rewrite sequencer files.
// Function
// - Once authentication passes, erase the target area with a block erase sequence.
// - Request write data from the host only after the erase has completed.
// - Each downloaded block is held in internal RAM before programming.
// - A writing end command stops requests, skips downloads and ends the rewrite.
// - Each received block is programmed as one 512-byte program operation.
// - Steps run in order: authenticate, erase, then download and program per block.
// - The sequence starts only after a start command from the host.
// - With target in another bank, the rewrite may run without copying code to RAM.
// - Erase loads address and entry, then writes 0x20 and then 0xd0.
// - Program writes 0xe8, 0x80, 512 bytes as words, then 0xd0.
// - Poll the ready flag; on timeout flag an error and issue forced end.
// - After each erase or program, check the command lock flag for errors.
package frs_pkg;

   // Clock rate and the ready poll timeout.
   localparam int unsigned FRS_CLK_MHZ = 20;
   localparam int unsigned FRS_TIMEOUT_US = 2000;
   localparam int unsigned FRS_TIMEOUT_CYC = FRS_TIMEOUT_US * FRS_CLK_MHZ;
   // The ready flag is ignored for this many cycles after each 0xd0 go command.
   localparam logic [19:0] FRS_RDY_BLANK = 20'h00002;

   // Block geometry: 512 bytes moved as 128 words of 32 bits.
   localparam int unsigned FRS_BLOCK_BYTES = 512;
   localparam int unsigned FRS_BLOCK_WORDS = FRS_BLOCK_BYTES / 4;
   localparam logic [6:0] FRS_LAST_WORD = 7'h7f;
   localparam logic [7:0] FRS_WORDS_PER_BLK = 8'h80;
   localparam logic [31:0] FRS_BLOCK_STEP = 32'h0000_0200;

   // Command codes written to the flash command area.
   localparam logic [31:0] FRS_CMD_ERASE = 32'h0000_0020;
   localparam logic [31:0] FRS_CMD_PROG = 32'h0000_00e8;
   localparam logic [31:0] FRS_CMD_PROG_CF = 32'h0000_0080;
   localparam logic [31:0] FRS_CMD_GO = 32'h0000_00d0;
   localparam logic [31:0] FRS_CMD_FORCE = 32'h0000_00ff;

   // Register byte offsets.
   localparam logic [7:0] FRS_OFS_CTRL = 8'h00;
   localparam logic [7:0] FRS_OFS_AREA = 8'h04;
   localparam logic [7:0] FRS_OFS_ENTRY = 8'h08;
   localparam logic [7:0] FRS_OFS_STATUS = 8'h0c;
   localparam logic [7:0] FRS_OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] FRS_OFS_IRQ_MASK = 8'h14;

   // Reset values.
   localparam logic [2:0] FRS_CTRL_RST = 3'h0;
   localparam logic [31:0] FRS_AREA_RST = 32'h0000_0000;
   localparam logic [15:0] FRS_ENTRY_RST = 16'h0000;
   localparam logic [4:0] FRS_IRQ_RST = 5'h00;

   // Field positions.
   localparam int unsigned FRS_CTRL_DIRECT = 0;
   localparam int unsigned FRS_CTRL_BANK_LSB = 1;
   localparam int unsigned FRS_ADDR_BANK_LSB = 22;
   localparam int unsigned FRS_IRQ_DONE = 0;
   localparam int unsigned FRS_IRQ_AUTH = 1;
   localparam int unsigned FRS_IRQ_TMO = 2;
   localparam int unsigned FRS_IRQ_LOCK = 3;
   localparam int unsigned FRS_IRQ_BLK = 4;

   // Sequencer states, one-hot.
   typedef enum logic [13:0] {
      S_IDLE = 14'h0001,
      S_COPY = 14'h0002,
      S_AUTH = 14'h0004,
      S_ERASE = 14'h0008,
      S_ERASE_GO = 14'h0010,
      S_WAIT = 14'h0020,
      S_CHECK = 14'h0040,
      S_REQ = 14'h0080,
      S_DL = 14'h0100,
      S_PROG = 14'h0200,
      S_PROG_CF = 14'h0400,
      S_PROG_DATA = 14'h0800,
      S_PROG_GO = 14'h1000,
      S_FORCE = 14'h2000
   } frs_state_e;

endpackage

// File: rtl/frs_block_ram.sv
// Block buffer RAM holding one downloaded 512-byte block.
`timescale 1ns/100ps
module frs_block_ram (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Write port.
   input wire logic wr_en_i,
   input wire logic [6:0] wr_addr_i,
   input wire logic [31:0] wr_data_i,
   // Read port, data one cycle after the address.
   input wire logic [6:0] rd_addr_i,
   output logic [31:0] rd_data_o
);
   import frs_pkg::*;

   logic [31:0] mem_q [0:FRS_BLOCK_WORDS-1];
   logic [31:0] rd_data_q;

   // The array has no reset; software never sees stale words since a
   // block is always fully downloaded before it is read out.
   always_ff @(posedge ref_clk_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end

   // Registered read keeps the flash data path free of array delay.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rd_data_q <= 32'h0000_0000;
      end else begin
         rd_data_q <= mem_q[rd_addr_i];
      end
   end

   assign rd_data_o = rd_data_q;

endmodule

// File: rtl/frs_sequencer.sv
// Flash rewrite sequencer with Wishbone registers and flash command port.
`timescale 1ns/100ps
module frs_sequencer #(
   parameter int unsigned TIMEOUT_CYC = frs_pkg::FRS_TIMEOUT_CYC
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Host command link.
   input wire logic host_start_i,
   input wire logic host_end_i,
   input wire logic dl_valid_i,
   input wire logic [31:0] dl_data_i,
   output logic data_req_o,
   // Authentication and code copy handshakes.
   output logic auth_req_o,
   input wire logic auth_done_i,
   input wire logic auth_ok_i,
   output logic copy_req_o,
   input wire logic copy_done_i,
   // Flash command interface.
   output logic flash_cmd_wr_o,
   output logic [31:0] flash_cmd_data_o,
   output logic [31:0] flash_start_address_o,
   output logic [15:0] flash_entry_select_o,
   input wire logic sequencer_ready_flag_i,
   input wire logic command_lock_flag_i,
   // Interrupt.
   output logic irq_o
);
   import frs_pkg::*;

   localparam logic [19:0] TMO_LAST = 20'(TIMEOUT_CYC - 1);

   // Byte lane mask from Wishbone select.
   function automatic logic [31:0] frs_wmask(input logic [3:0] sel);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[8*i +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction

   // Word decode of a register offset.
   function automatic logic frs_hit(input logic [7:0] adr,
                                    input logic [7:0] ofs);
      return adr[7:2] == ofs[7:2];
   endfunction

   frs_state_e state_q, state_d;
   logic [6:0] cnt_q, cnt_d;
   logic [19:0] tmo_q, tmo_d;
   logic op_prog_q, op_prog_d;
   logic end_seen_q, end_seen_d;
   logic erased_q, erased_d;
   logic [31:0] addr_q, addr_d;
   logic [7:0] blk_q, blk_d;
   logic fwr_q, fwr_d;
   logic [31:0] fdat_q, fdat_d;
   logic req_q, req_d;
   logic [4:0] ev;
   logic direct_ok;
   logic ram_we;
   logic [6:0] ram_raddr;
   logic [31:0] ram_rdata;
   logic [2:0] ctrl_q, ctrl_d;
   logic [31:0] area_q, area_d;
   logic [15:0] entry_q, entry_d;
   logic [4:0] mask_q, mask_d;
   logic [4:0] stat_q, stat_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic wb_req, wb_wr;
   logic [31:0] wm;

   // Direct run from flash only when the target bank differs from the
   // code bank; otherwise the code copy to RAM must finish first.
   assign direct_ok = ctrl_q[FRS_CTRL_DIRECT] &&
      (area_q[FRS_ADDR_BANK_LSB +: 2] != ctrl_q[FRS_CTRL_BANK_LSB +: 2]);

   // Block buffer: download writes, programming reads one word ahead.
   assign ram_we = (state_q == S_DL) && dl_valid_i && !host_end_i;
   assign ram_raddr = (state_q == S_PROG_CF) ? 7'h00 : 7'(cnt_q + 7'h01);

   frs_block_ram u_ram (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .wr_en_i(ram_we),
      .wr_addr_i(cnt_q),
      .wr_data_i(dl_data_i),
      .rd_addr_i(ram_raddr),
      .rd_data_o(ram_rdata)
   );

   // Sequencer next state.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      tmo_d = tmo_q;
      op_prog_d = op_prog_q;
      erased_d = erased_q;
      addr_d = addr_q;
      blk_d = blk_q;
      fwr_d = 1'b0;
      fdat_d = fdat_q;
      req_d = 1'b0;
      ev = 5'h00;
      end_seen_d = end_seen_q | (host_end_i && state_q != S_IDLE);
      case (state_q)
         S_IDLE: begin
            if (host_start_i) begin
               end_seen_d = 1'b0;
               erased_d = 1'b0;
               blk_d = 8'h00;
               addr_d = area_q;
               state_d = direct_ok ? S_AUTH : S_COPY;
            end
         end
         S_COPY: begin
            if (copy_done_i) begin
               state_d = S_AUTH;
            end
         end
         S_AUTH: begin
            if (auth_done_i) begin
               if (auth_ok_i) begin
                  state_d = S_ERASE;
               end else begin
                  ev[FRS_IRQ_AUTH] = 1'b1;
                  state_d = S_IDLE;
               end
            end
         end
         S_ERASE: begin
            fwr_d = 1'b1;
            fdat_d = FRS_CMD_ERASE;
            state_d = S_ERASE_GO;
         end
         S_ERASE_GO: begin
            fwr_d = 1'b1;
            fdat_d = FRS_CMD_GO;
            op_prog_d = 1'b0;
            tmo_d = 20'h00000;
            state_d = S_WAIT;
         end
         S_WAIT: begin
            // Ready is blanked briefly so the flag left over from the
            // previous operation is not taken as completion.
            if (sequencer_ready_flag_i && tmo_q >= FRS_RDY_BLANK) begin
               state_d = S_CHECK;
            end else if (tmo_q == TMO_LAST) begin
               ev[FRS_IRQ_TMO] = 1'b1;
               state_d = S_FORCE;
            end else begin
               tmo_d = 20'(tmo_q + 20'h00001);
            end
         end
         S_CHECK: begin
            if (command_lock_flag_i) begin
               ev[FRS_IRQ_LOCK] = 1'b1;
               state_d = S_IDLE;
            end else if (op_prog_q) begin
               ev[FRS_IRQ_BLK] = 1'b1;
               blk_d = 8'(blk_q + 8'h01);
               addr_d = 32'(addr_q + FRS_BLOCK_STEP);
               state_d = S_REQ;
            end else begin
               erased_d = 1'b1;
               state_d = S_REQ;
            end
         end
         S_REQ: begin
            if (end_seen_d) begin
               ev[FRS_IRQ_DONE] = 1'b1;
               state_d = S_IDLE;
            end else begin
               req_d = 1'b1;
               cnt_d = 7'h00;
               state_d = S_DL;
            end
         end
         S_DL: begin
            if (host_end_i) begin
               ev[FRS_IRQ_DONE] = 1'b1;
               state_d = S_IDLE;
            end else if (dl_valid_i) begin
               cnt_d = 7'(cnt_q + 7'h01);
               if (cnt_q == FRS_LAST_WORD) begin
                  state_d = S_PROG;
               end
            end
         end
         S_PROG: begin
            fwr_d = 1'b1;
            fdat_d = FRS_CMD_PROG;
            state_d = S_PROG_CF;
         end
         S_PROG_CF: begin
            fwr_d = 1'b1;
            fdat_d = FRS_CMD_PROG_CF;
            cnt_d = 7'h00;
            state_d = S_PROG_DATA;
         end
         S_PROG_DATA: begin
            fwr_d = 1'b1;
            fdat_d = ram_rdata;
            cnt_d = 7'(cnt_q + 7'h01);
            if (cnt_q == FRS_LAST_WORD) begin
               state_d = S_PROG_GO;
            end
         end
         S_PROG_GO: begin
            fwr_d = 1'b1;
            fdat_d = FRS_CMD_GO;
            op_prog_d = 1'b1;
            tmo_d = 20'h00000;
            state_d = S_WAIT;
         end
         S_FORCE: begin
            fwr_d = 1'b1;
            fdat_d = FRS_CMD_FORCE;
            state_d = S_IDLE;
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_q <= S_IDLE;
         cnt_q <= 7'h00;
         tmo_q <= 20'h00000;
         op_prog_q <= 1'b0;
         end_seen_q <= 1'b0;
         erased_q <= 1'b0;
         addr_q <= FRS_AREA_RST;
         blk_q <= 8'h00;
         fwr_q <= 1'b0;
         fdat_q <= 32'h0000_0000;
         req_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         tmo_q <= tmo_d;
         op_prog_q <= op_prog_d;
         end_seen_q <= end_seen_d;
         erased_q <= erased_d;
         addr_q <= addr_d;
         blk_q <= blk_d;
         fwr_q <= fwr_d;
         fdat_q <= fdat_d;
         req_q <= req_d;
      end
   end

   // Bus side next values; the answer comes one cycle after the request.
   always_comb begin
      wb_req = wb_cyc_i && wb_stb_i && !ack_q;
      wb_wr = wb_req && wb_we_i;
      wm = frs_wmask(wb_sel_i);
      ack_d = wb_req;
      ctrl_d = ctrl_q;
      area_d = area_q;
      entry_d = entry_q;
      mask_d = mask_q;
      rdat_d = rdat_q;
      if (wb_wr && frs_hit(wb_adr_i, FRS_OFS_CTRL)) begin
         ctrl_d = (ctrl_q & ~wm[2:0]) | (wb_dat_i[2:0] & wm[2:0]);
      end
      if (wb_wr && frs_hit(wb_adr_i, FRS_OFS_AREA)) begin
         area_d = (area_q & ~wm) | (wb_dat_i & wm);
      end
      if (wb_wr && frs_hit(wb_adr_i, FRS_OFS_ENTRY)) begin
         entry_d = (entry_q & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
      end
      if (wb_wr && frs_hit(wb_adr_i, FRS_OFS_IRQ_MASK)) begin
         mask_d = (mask_q & ~wm[4:0]) | (wb_dat_i[4:0] & wm[4:0]);
      end
      // A new event wins over a write-one clear in the same cycle.
      stat_d = stat_q | ev;
      if (wb_wr && frs_hit(wb_adr_i, FRS_OFS_IRQ_STAT)) begin
         stat_d = (stat_q & ~(wb_dat_i[4:0] & wm[4:0])) | ev;
      end
      if (wb_req) begin
         case (wb_adr_i[7:2])
            FRS_OFS_CTRL[7:2]: rdat_d = {29'h0, ctrl_q};
            FRS_OFS_AREA[7:2]: rdat_d = area_q;
            FRS_OFS_ENTRY[7:2]: rdat_d = {16'h0, entry_q};
            FRS_OFS_STATUS[7:2]:
               rdat_d = {6'h0, erased_q, end_seen_q, blk_q, 2'h0, state_q};
            FRS_OFS_IRQ_STAT[7:2]: rdat_d = {27'h0, stat_q};
            FRS_OFS_IRQ_MASK[7:2]: rdat_d = {27'h0, mask_q};
            default: rdat_d = 32'h0000_0000;
         endcase
      end
   end

   // Bus side registers.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
         ctrl_q <= FRS_CTRL_RST;
         area_q <= FRS_AREA_RST;
         entry_q <= FRS_ENTRY_RST;
         mask_q <= FRS_IRQ_RST;
         stat_q <= FRS_IRQ_RST;
      end else begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         ctrl_q <= ctrl_d;
         area_q <= area_d;
         entry_q <= entry_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
      end
   end

   // Outputs.
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign data_req_o = req_q;
   assign auth_req_o = (state_q == S_AUTH);
   assign copy_req_o = (state_q == S_COPY);
   assign flash_cmd_wr_o = fwr_q;
   assign flash_cmd_data_o = fdat_q;
   assign flash_start_address_o = addr_q;
   assign flash_entry_select_o = entry_q;
   assign irq_o = |(stat_q & mask_q);

   // Helper: counts data words written in one program operation.
   logic [7:0] a_words_q;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || state_q == S_PROG_CF) begin
         a_words_q <= 8'h00;
      end else if (state_q == S_PROG_DATA) begin
         a_words_q <= 8'(a_words_q + 8'h01);
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_auth_to_erase: assert property (state_q == S_AUTH && auth_done_i &&
      auth_ok_i |=> state_q == S_ERASE) else $error("erase not after auth");
   a_req_erased: assert property (data_req_o |-> erased_q)
      else $error("data request before erase done");
   a_dl_to_prog: assert property (state_q == S_DL && dl_valid_i &&
      !host_end_i && cnt_q == FRS_LAST_WORD |=> state_q == S_PROG)
      else $error("full block not programmed");
   a_end_stops_req: assert property (state_q == S_REQ && end_seen_q
      |=> !data_req_o && state_q == S_IDLE) else $error("request after end");
   a_block_words: assert property (state_q == S_PROG_GO |->
      a_words_q == FRS_WORDS_PER_BLK) else $error("block word count wrong");
   a_order_erase: assert property ($rose(state_q == S_PROG) |->
      erased_q) else $error("program before erase");
   a_start_gate: assert property (state_q == S_IDLE &&
      state_d != S_IDLE |-> host_start_i) else $error("run without start");
   a_bank_copy: assert property (state_q == S_IDLE && host_start_i &&
      !direct_ok |=> state_q == S_COPY) else $error("copy step skipped");
   a_erase_cmds: assert property (state_q == S_ERASE |=>
      flash_cmd_wr_o && flash_cmd_data_o == FRS_CMD_ERASE ##1
      flash_cmd_wr_o && flash_cmd_data_o == FRS_CMD_GO)
      else $error("erase command pair wrong");
   a_prog_head: assert property (state_q == S_PROG |=>
      flash_cmd_wr_o && flash_cmd_data_o == FRS_CMD_PROG ##1
      flash_cmd_wr_o && flash_cmd_data_o == FRS_CMD_PROG_CF)
      else $error("program header wrong");
   a_timeout_force: assert property (state_q == S_WAIT &&
      !sequencer_ready_flag_i && tmo_q == TMO_LAST |=> state_q == S_FORCE
      ##1 flash_cmd_wr_o && flash_cmd_data_o == FRS_CMD_FORCE &&
      stat_q[FRS_IRQ_TMO]) else $error("timeout not forced");
   a_lock_error: assert property (state_q == S_CHECK &&
      command_lock_flag_i |=> state_q == S_IDLE && stat_q[FRS_IRQ_LOCK])
      else $error("lock error missed");

   c_erase_done: cover property (state_q == S_CHECK && !op_prog_q ##1
      state_q == S_REQ);
   c_block_prog: cover property (state_q == S_PROG_GO);
   c_done: cover property (state_q == S_DL && host_end_i);
   c_timeout: cover property (state_q == S_FORCE);

endmodule

// File: bench/frs_host_model.sv
// Behavioural host tool and flash macro facing the rewrite sequencer.
`timescale 1ns/100ps
module frs_host_model (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Bench controls: hold ready low, raise lock, authentication result.
   input wire logic stall_i,
   input wire logic lock_i,
   input wire logic pass_i,
   // Sequencer side.
   input wire logic data_req_i,
   input wire logic auth_req_i,
   input wire logic copy_req_i,
   input wire logic flash_cmd_wr_i,
   input wire logic [31:0] flash_cmd_data_i,
   output logic dl_valid_o,
   output logic [31:0] dl_data_o,
   output logic auth_done_o,
   output logic auth_ok_o,
   output logic copy_done_o,
   output logic ready_o,
   output logic lock_o
);
   logic [31:0] log_q[$];
   int busy, words, blk, ac, cc;
   int req_cnt = 0;
   logic gap;

   // Quiet, known outputs before the first clock edge.
   initial begin
      dl_valid_o = 1'b0;
      dl_data_o = 32'h5a5a_a5a5;
      auth_done_o = 1'b0;
      auth_ok_o = 1'b0;
      copy_done_o = 1'b0;
      ready_o = 1'b1;
      lock_o = 1'b0;
   end

   // The flash logs every command word and stays busy after a start code.
   // The host answers a request with one block, idle cycles between words,
   // so the sequencer cannot rely on back-to-back data.
   always @(posedge ref_clk_i) begin
      dl_valid_o <= 1'b0;
      auth_done_o <= 1'b0;
      copy_done_o <= 1'b0;
      auth_ok_o <= ~auth_ok_o;
      dl_data_o <= ~dl_data_o; // Idle data never holds its last value.
      if (!rst_n_i) begin
         busy = 0;
         words = 0;
         blk = 0;
         gap = 1'b0;
      end else begin
         if (flash_cmd_wr_i) begin
            log_q.push_back(flash_cmd_data_i);
            if (flash_cmd_data_i == 32'h0000_00d0) busy = 5;
         end else if (busy > 0) begin
            busy--;
         end
         if (data_req_i) begin
            words = 128;
            req_cnt++;
         end else if (words > 0 && gap) begin
            dl_valid_o <= 1'b1;
            dl_data_o <= {blk[15:0], 16'(128 - words)};
            words--;
            if (words == 0) blk++;
         end
         gap = ~gap;
      end
      ac = auth_req_i ? ac + 1 : 0;
      cc = copy_req_i ? cc + 1 : 0;
      if (ac == 3) begin
         auth_done_o <= 1'b1;
         auth_ok_o <= pass_i;
      end
      if (cc == 3) copy_done_o <= 1'b1;
      ready_o <= busy == 0 && !stall_i;
      lock_o <= lock_i;
   end
endmodule

// File: bench/frs_sequencer_test.sv
// Self-checking bench for the flash rewrite sequencer.
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
   error_cnt++; $display("mismatch %s exp %h got %h", nm, e, a); end end
`define WAITF(c) begin k = 0; while (!(c) && k < 3000) begin \
   @(posedge ref_clk_i); k++; end if (k >= 3000) abort_run(); end
module frs_sequencer_test;
   import frs_pkg::*;
   localparam logic [31:0] AREA = 32'h0040_0000;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, hs = 1'b0, he = 1'b0;
   logic stall = 1'b0, lockm = 1'b0, pass = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rd, rdat, dl_data, fdat, faddr;
   logic [15:0] fentry;
   logic ack, dl_valid, data_req, auth_req, auth_done, auth_ok;
   logic copy_req, copy_done, fwr, rdy, lock, irq;
   int error_cnt = 0, n_compared = 0, k, n0;

   // Short timeout keeps the stalled-flash case brief.
   frs_sequencer #(.TIMEOUT_CYC(20)) DUT (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
      .host_start_i(hs), .host_end_i(he), .dl_valid_i(dl_valid),
      .dl_data_i(dl_data), .data_req_o(data_req), .auth_req_o(auth_req),
      .auth_done_i(auth_done), .auth_ok_i(auth_ok),
      .copy_req_o(copy_req), .copy_done_i(copy_done),
      .flash_cmd_wr_o(fwr), .flash_cmd_data_o(fdat),
      .flash_start_address_o(faddr), .flash_entry_select_o(fentry),
      .sequencer_ready_flag_i(rdy), .command_lock_flag_i(lock),
      .irq_o(irq));

   frs_host_model u_host (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .stall_i(stall),
      .lock_i(lockm), .pass_i(pass), .data_req_i(data_req),
      .auth_req_i(auth_req), .copy_req_i(copy_req),
      .flash_cmd_wr_i(fwr), .flash_cmd_data_i(fdat),
      .dl_valid_o(dl_valid), .dl_data_o(dl_data),
      .auth_done_o(auth_done), .auth_ok_o(auth_ok),
      .copy_done_o(copy_done), .ready_o(rdy), .lock_o(lock));

   // Free-running system clock, 50 ns period.
   always #25 ref_clk_i = ~ref_clk_i;

   // Verdict and end of run; every hang limit also lands here.
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic abort_run();
      error_cnt++;
      report_and_stop();
   endtask

   // One classic Wishbone cycle; read data lands in rd.
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      @(posedge ref_clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = rdat;
      if (n >= 20) abort_run();
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // One-cycle command pulse from the host.
   task automatic pulse(input logic end_cmd);
      @(posedge ref_clk_i);
      if (end_cmd) he <= 1'b1;
      else hs <= 1'b1;
      @(posedge ref_clk_i);
      he <= 1'b0;
      hs <= 1'b0;
   endtask

   // Reset values, unmapped and read-only places, no start without command.
   task automatic t_regs();
      for (int i = 0; i < 7; i++) begin
         wb(1'b0, 8'(4 * i), 32'h0);
         `CHK("rst", (i == 3) ? 32'h1 : 32'h0, rd)
         wb(1'b1, 8'(4 * i), 32'hffff_ffe0);
         wb(1'b0, 8'(4 * i), 32'h0);
         `CHK("reg", (i == 1) ? 32'hffff_ffe0 : (i == 2) ? 32'h0000_ffe0 :
            (i == 3) ? 32'h1 : 32'h0, rd)
      end
      `CHK("auth_req idle", 1'b0, auth_req)
      `CHK("copy_req idle", 1'b0, copy_req)
      wb(1'b1, FRS_OFS_ENTRY, 32'h0000_00aa);
   endtask

   // Direct run: erase, one block programmed, end in mid-download.
   task automatic t_run();
      wb(1'b1, FRS_OFS_AREA, AREA);
      wb(1'b1, FRS_OFS_CTRL, 32'h1);
      wb(1'b1, FRS_OFS_IRQ_MASK, 32'h1f);
      wb(1'b1, FRS_OFS_IRQ_STAT, 32'h1f);
      u_host.log_q.delete();
      pulse(1'b0);
      `WAITF(auth_req === 1'b1)
      `CHK("copy_req", 1'b0, copy_req)
      `WAITF(data_req === 1'b1)
      `CHK("cmds before req", 2, u_host.log_q.size())
      `CHK("erase code", FRS_CMD_ERASE, u_host.log_q[0])
      `CHK("erase go", FRS_CMD_GO, u_host.log_q[1])
      `CHK("erase addr", AREA, faddr)
      `CHK("entry", 16'h00aa, fentry)
      `WAITF(u_host.log_q.size() == 133)
      `CHK("prog code", FRS_CMD_PROG, u_host.log_q[2])
      `CHK("prog cf", FRS_CMD_PROG_CF, u_host.log_q[3])
      for (int i = 0; i < 128; i++) begin
         `CHK("word", {16'h0, 16'(i)}, u_host.log_q[4 + i])
      end
      `CHK("prog go", FRS_CMD_GO, u_host.log_q[132])
      `WAITF(data_req === 1'b1)
      `CHK("next addr", AREA + FRS_BLOCK_STEP, faddr)
      wb(1'b0, FRS_OFS_STATUS, 32'h0);
      `CHK("blocks", 8'h01, rd[23:16])
      pulse(1'b1);
      repeat (300) @(posedge ref_clk_i);
      `CHK("after end", 133, u_host.log_q.size())
      wb(1'b0, FRS_OFS_STATUS, 32'h0);
      `CHK("idle end", 2'b11, {rd[24], rd[0]})
      wb(1'b0, FRS_OFS_IRQ_STAT, 32'h0);
      `CHK("irq stat", 5'h11, rd[4:0])
      `CHK("irq on", 1'b1, irq)
      wb(1'b1, FRS_OFS_IRQ_STAT, 32'h11);
      @(posedge ref_clk_i);
      `CHK("irq off", 1'b0, irq)
   endtask

   // Stalled flash: forced end, masked interrupt stays low.
   task automatic t_tmo();
      wb(1'b1, FRS_OFS_IRQ_MASK, 32'h0);
      stall <= 1'b1;
      u_host.log_q.delete();
      pulse(1'b0);
      `WAITF(u_host.log_q.size() == 3)
      `CHK("force", FRS_CMD_FORCE, u_host.log_q[2])
      wb(1'b0, FRS_OFS_IRQ_STAT, 32'h0);
      `CHK("tmo flag", 1'b1, rd[FRS_IRQ_TMO])
      `CHK("masked irq", 1'b0, irq)
      stall <= 1'b0;
      wb(1'b1, FRS_OFS_IRQ_STAT, 32'h1f);
   endtask

   // Lock error after erase: no request, no programming.
   task automatic t_lock();
      lockm <= 1'b1;
      n0 = u_host.req_cnt;
      u_host.log_q.delete();
      pulse(1'b0);
      repeat (100) @(posedge ref_clk_i);
      `CHK("lock cmds", 2, u_host.log_q.size())
      `CHK("lock reqs", n0, u_host.req_cnt)
      wb(1'b0, FRS_OFS_IRQ_STAT, 32'h0);
      `CHK("lock flag", 1'b1, rd[FRS_IRQ_LOCK])
      lockm <= 1'b0;
      wb(1'b1, FRS_OFS_IRQ_STAT, 32'h1f);
      // End while authenticating: erase runs, then the run stops at the
      // request point without asking the host for data.
      u_host.log_q.delete();
      pulse(1'b0);
      pulse(1'b1);
      repeat (100) @(posedge ref_clk_i);
      `CHK("end reqs", n0, u_host.req_cnt)
      `CHK("end cmds", 2, u_host.log_q.size())
      wb(1'b0, FRS_OFS_IRQ_STAT, 32'h0);
      `CHK("end done", 5'h01, rd[4:0])
      wb(1'b1, FRS_OFS_IRQ_STAT, 32'h1f);
   endtask

   // Copy path with failed authentication: nothing reaches the flash.
   task automatic t_copy();
      // Direct run asked for, but target and code share bank 1.
      wb(1'b1, FRS_OFS_CTRL, 32'h3);
      pass <= 1'b0;
      u_host.log_q.delete();
      pulse(1'b0);
      `WAITF(copy_req === 1'b1)
      `CHK("auth early", 1'b0, auth_req)
      repeat (30) @(posedge ref_clk_i);
      wb(1'b0, FRS_OFS_IRQ_STAT, 32'h0);
      `CHK("auth fail", 1'b1, rd[FRS_IRQ_AUTH])
      `CHK("no erase", 0, u_host.log_q.size())
   endtask

   // Reset for three cycles, then every scenario in turn.
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_run();
      t_tmo();
      t_lock();
      t_copy();
      report_and_stop();
   end
endmodule
